/* File: logic/lip_pkg.sv */
// package: constants and types of the led intensity pwm block
`default_nettype none
package lip_pkg;
  // outputs and register map
  localparam int unsigned LIP_NUM_OUT      = 9;
  localparam int unsigned LIP_NUM_PAIR_OUT = 8;
  localparam logic [7:0]  LIP_ADDR_MASTER  = 8'h0e;
  localparam logic [7:0]  LIP_ADDR_PAIR_LO = 8'h10;
  localparam logic [7:0]  LIP_ADDR_PAIR_HI = 8'h13;
  localparam logic [7:0]  LIP_RDATA_NONE   = 8'h00;
  // field positions: upper nibble is master or odd output, lower nibble ninth or even output
  localparam int unsigned LIP_HI_LSB       = 4;
  localparam int unsigned LIP_LO_LSB       = 0;
  localparam int unsigned LIP_NIB_W        = 4;
  // values after reset
  localparam logic [3:0]  LIP_MASTER_RST   = 4'h0;
  localparam logic [3:0]  LIP_NINTH_RST    = 4'h0;
  localparam logic [3:0]  LIP_LEVEL_RST    = 4'h0;
  // special codes
  localparam logic [3:0]  LIP_LEVEL_STATIC = 4'hf;
  localparam logic [3:0]  LIP_MASTER_OFF   = 4'h0;
  // oscillator timing: one sub-step every LIP_OSC_DIV clocks
  localparam int unsigned LIP_CLK_PERIOD_NS = 10;
  localparam int unsigned LIP_SUB_PERIOD_NS = 40;
  localparam int unsigned LIP_OSC_DIV       = LIP_SUB_PERIOD_NS / LIP_CLK_PERIOD_NS;
  localparam logic [1:0]  LIP_DIV_LAST      = 2'(LIP_OSC_DIV - 1);
  localparam logic [1:0]  LIP_DIV_RST       = 2'h0;
  // 15 master sub-steps per slot, 16 individual slots per pwm cycle
  localparam logic [3:0]  LIP_SUB_LAST      = 4'he;
  localparam logic [3:0]  LIP_SLOT_LAST     = 4'hf;
  localparam logic [3:0]  LIP_CNT_RST       = 4'h0;

  typedef enum logic {
    LIP_OSC_OFF = 1'b0,
    LIP_OSC_RUN = 1'b1
  } lip_osc_e;

  // register access from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lip_reg_req_s;

  // position inside the pwm cycle
  typedef struct packed {
    logic [3:0] slot;
    logic [3:0] sub;
  } lip_pwm_pos_s;
endpackage
`default_nettype wire

/* File: logic/lip_pwm_chan.sv */
// module: waveform of one open-drain output from its level, phase bit and master
`default_nettype none
module lip_pwm_chan
  import lip_pkg::*;
(
  // settings
  input  wire logic [3:0]   i_level,
  input  wire logic         i_phase_bit,
  input  wire logic [3:0]   i_master,
  // cycle position
  input  wire lip_pwm_pos_s i_pos,
  // sink request, high means pull the pin low
  output logic              o_sink
);
  logic ind_on;

  // individual 16-slot window, then master gating inside each slot
  always_comb begin
    if (i_phase_bit) begin
      ind_on = (i_pos.slot > i_level); // low for (15-n)/16
    end else begin
      ind_on = (i_pos.slot <= i_level); // low for (n+1)/16
    end
    if (i_master == LIP_MASTER_OFF) begin
      o_sink = 1'b0; // master off: static, led off
    end else if (i_level == LIP_LEVEL_STATIC) begin
      o_sink = ~i_phase_bit; // static low or static high impedance
    end else begin
      o_sink = ind_on && (i_pos.sub < i_master); // m/15 of each slot
    end
  end
endmodule
`default_nettype wire

/* File: logic/lip_pwm_top.sv */
// module: led intensity pwm with blink-phase polarity and intensity registers
`default_nettype none
module lip_pwm_top
  import lip_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // register access
  input  wire lip_reg_req_s           i_reg_req,
  output logic [7:0]                  o_reg_rdata,
  // blink state from the blink logic
  input  wire logic                   i_blink_phase,
  input  wire logic [LIP_NUM_OUT-1:0] i_phase0_bits,
  input  wire logic [LIP_NUM_OUT-1:0] i_phase1_bits,
  // open-drain output pins
  input  wire logic [LIP_NUM_OUT-1:0] i_port_in,
  output logic      [LIP_NUM_OUT-1:0] o_port_out,
  output logic      [LIP_NUM_OUT-1:0] o_port_oe,
  output logic      [LIP_NUM_OUT-1:0] o_port_level
);

  // address decode shared by write and read
  function automatic logic pair_hit(input logic [7:0] addr);
    pair_hit = (addr >= LIP_ADDR_PAIR_LO) && (addr <= LIP_ADDR_PAIR_HI);
  endfunction

  function automatic int unsigned pair_index(input logic [7:0] addr);
    pair_index = int'(addr[1:0]);
  endfunction

  // register state
  logic [3:0]   master_ff;
  logic [3:0]   nxt_master;
  logic [3:0]   ninth_ff;
  logic [3:0]   nxt_ninth;
  logic [3:0]   level_ff  [LIP_NUM_PAIR_OUT];
  logic [3:0]   nxt_level [LIP_NUM_PAIR_OUT];
  logic [7:0]   rdata_ff;
  logic [7:0]   nxt_rdata;
  // oscillator state
  lip_osc_e     osc_state_ff;
  lip_osc_e     nxt_osc_state;
  logic [1:0]   div_ff;
  logic [1:0]   nxt_div;
  logic [3:0]   sub_ff;
  logic [3:0]   nxt_sub;
  logic [3:0]   slot_ff;
  logic [3:0]   nxt_slot;
  lip_pwm_pos_s pos;
  // output state
  logic [LIP_NUM_OUT-1:0] act_phase;
  logic [LIP_NUM_OUT-1:0] sink;
  logic [LIP_NUM_OUT-1:0] oe_ff;
  logic [LIP_NUM_OUT-1:0] out_ff;
  logic [LIP_NUM_OUT-1:0] sync1_ff;
  logic [LIP_NUM_OUT-1:0] sync2_ff;

  // register writes and reads
  always_comb begin
    nxt_master = master_ff;
    nxt_ninth  = ninth_ff;
    nxt_rdata  = rdata_ff;
    for (int i = 0; i < LIP_NUM_PAIR_OUT; i++) begin
      nxt_level[i] = level_ff[i];
    end
    if (i_reg_req.wr) begin
      if (i_reg_req.addr == LIP_ADDR_MASTER) begin
        nxt_master = i_reg_req.wdata[LIP_HI_LSB +: LIP_NIB_W];
        nxt_ninth  = i_reg_req.wdata[LIP_LO_LSB +: LIP_NIB_W];
      end else if (pair_hit(i_reg_req.addr)) begin
        nxt_level[2*pair_index(i_reg_req.addr)+1] =
          i_reg_req.wdata[LIP_HI_LSB +: LIP_NIB_W]; // odd output upper
        nxt_level[2*pair_index(i_reg_req.addr)] =
          i_reg_req.wdata[LIP_LO_LSB +: LIP_NIB_W];
      end
    end
    if (i_reg_req.rd) begin
      if (i_reg_req.addr == LIP_ADDR_MASTER) begin
        nxt_rdata = {master_ff, ninth_ff};
      end else if (pair_hit(i_reg_req.addr)) begin
        nxt_rdata = {level_ff[2*pair_index(i_reg_req.addr)+1],
                     level_ff[2*pair_index(i_reg_req.addr)]};
      end else begin
        nxt_rdata = LIP_RDATA_NONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      master_ff <= LIP_MASTER_RST;
      ninth_ff  <= LIP_NINTH_RST;
      rdata_ff  <= LIP_RDATA_NONE;
      for (int i = 0; i < LIP_NUM_PAIR_OUT; i++) begin
        level_ff[i] <= LIP_LEVEL_RST;
      end
    end else begin
      master_ff <= nxt_master;
      ninth_ff  <= nxt_ninth;
      rdata_ff  <= nxt_rdata;
      for (int i = 0; i < LIP_NUM_PAIR_OUT; i++) begin
        level_ff[i] <= nxt_level[i];
      end
    end
  end

  // internal oscillator: divider, 15 sub-steps per slot, 16 slots per cycle
  always_comb begin
    nxt_osc_state = osc_state_ff;
    nxt_div       = div_ff;
    nxt_sub       = sub_ff;
    nxt_slot      = slot_ff;
    if (master_ff == LIP_MASTER_OFF) begin
      nxt_osc_state = LIP_OSC_OFF; // oscillator stopped
      nxt_div       = LIP_DIV_RST;
      nxt_sub       = LIP_CNT_RST;
      nxt_slot      = LIP_CNT_RST;
    end else begin
      nxt_osc_state = LIP_OSC_RUN;
      unique case (osc_state_ff)
        LIP_OSC_OFF: begin
          nxt_div = LIP_DIV_RST; // restart cleanly from the cycle start
        end
        LIP_OSC_RUN: begin
          if (div_ff == LIP_DIV_LAST) begin
            nxt_div = LIP_DIV_RST;
            if (sub_ff == LIP_SUB_LAST) begin
              nxt_sub  = LIP_CNT_RST;
              nxt_slot = (slot_ff == LIP_SLOT_LAST) ? LIP_CNT_RST : slot_ff + 4'h1;
            end else begin
              nxt_sub = sub_ff + 4'h1;
            end
          end else begin
            nxt_div = div_ff + 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_state_ff <= LIP_OSC_OFF;
      div_ff       <= LIP_DIV_RST;
      sub_ff       <= LIP_CNT_RST;
      slot_ff      <= LIP_CNT_RST;
    end else begin
      osc_state_ff <= nxt_osc_state;
      div_ff       <= nxt_div;
      sub_ff       <= nxt_sub;
      slot_ff      <= nxt_slot;
    end
  end

  assign pos.slot = slot_ff;
  assign pos.sub  = sub_ff;

  // one waveform generator per output
  generate
    for (genvar g = 0; g < LIP_NUM_OUT; g++) begin : g_chan
      logic [3:0] lvl;
      if (g == LIP_NUM_OUT - 1) begin : g_ninth
        assign lvl = ninth_ff;
      end else begin : g_pair
        assign lvl = level_ff[g];
      end
      assign act_phase[g] = i_blink_phase ? i_phase1_bits[g] : i_phase0_bits[g];
      lip_pwm_chan u_chan (
        .i_level     (lvl),
        .i_phase_bit (act_phase[g]),
        .i_master    (master_ff),
        .i_pos       (pos),
        .o_sink      (sink[g])
      );
    end
  endgenerate

  // pins: drive low while sinking, release otherwise; pin levels synchronised
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_ff    <= '0;
      out_ff   <= '0;
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      oe_ff    <= sink; // enable only to pull low
      out_ff   <= '0;   // open drain never drives high
      sync1_ff <= i_port_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign o_port_oe    = oe_ff;
  assign o_port_out   = out_ff;
  assign o_port_level = sync2_ff;
  assign o_reg_rdata  = rdata_ff;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  master_off_pins_a: assert property (
    (master_ff == LIP_MASTER_OFF) |=> (o_port_oe == '0))
    else $error("outputs switch while master level is zero");
  osc_stopped_a: assert property (
    (master_ff == LIP_MASTER_OFF) [*2] |-> (osc_state_ff == LIP_OSC_OFF) && (sub_ff == LIP_CNT_RST))
    else $error("oscillator runs while master level is zero");
  static_low_a: assert property (
    (master_ff != LIP_MASTER_OFF && ninth_ff == LIP_LEVEL_STATIC && !act_phase[8])
    |=> o_port_oe[8])
    else $error("static level with phase bit 0 not held low");
  static_hiz_a: assert property (
    (ninth_ff == LIP_LEVEL_STATIC && act_phase[8]) |=> !o_port_oe[8])
    else $error("static level with phase bit 1 not high impedance");
  master_write_a: assert property (
    (i_reg_req.wr && i_reg_req.addr == LIP_ADDR_MASTER)
    |=> ({master_ff, ninth_ff} == $past(i_reg_req.wdata)))
    else $error("master and ninth levels not stored");
  master_read_a: assert property (
    (i_reg_req.rd && !i_reg_req.wr && i_reg_req.addr == LIP_ADDR_MASTER)
    |=> (o_reg_rdata == {master_ff, ninth_ff}))
    else $error("master register read-back differs");
  pair_write_a: assert property (
    (i_reg_req.wr && i_reg_req.addr == LIP_ADDR_PAIR_LO + 8'h01)
    |=> (level_ff[3] == $past(i_reg_req.wdata[7:4]))
        && (level_ff[2] == $past(i_reg_req.wdata[3:0])))
    else $error("output pair levels stored in wrong nibbles");
  slot_wrap_a: assert property (
    (osc_state_ff == LIP_OSC_RUN && master_ff != LIP_MASTER_OFF && div_ff == LIP_DIV_LAST
     && sub_ff == LIP_SUB_LAST && slot_ff == LIP_SLOT_LAST) |=> (slot_ff == 4'h0))
    else $error("pwm cycle does not wrap after slot 15");
  master_scale_a: assert property (
    (master_ff != LIP_MASTER_OFF && ninth_ff != LIP_LEVEL_STATIC && sub_ff >= master_ff)
    |=> !o_port_oe[8])
    else $error("output sinks beyond master share of the slot");
  phase0_duty_a: assert property (
    (master_ff == 4'hf && ninth_ff != LIP_LEVEL_STATIC && !act_phase[8] && slot_ff <= ninth_ff)
    |=> o_port_oe[8])
    else $error("phase 0 low window missing");
  phase1_duty_a: assert property (
    (master_ff == 4'hf && ninth_ff != LIP_LEVEL_STATIC && act_phase[8] && slot_ff <= ninth_ff)
    |=> !o_port_oe[8])
    else $error("phase 1 waveform not inverted");
  phase0_off_a: assert property (
    (master_ff == 4'hf && ninth_ff != LIP_LEVEL_STATIC && !act_phase[8] && slot_ff > ninth_ff)
    |=> !o_port_oe[8])
    else $error("phase 0 output sinks beyond its window");
  phase1_on_a: assert property (
    (master_ff == 4'hf && ninth_ff != LIP_LEVEL_STATIC && act_phase[8] && slot_ff > ninth_ff)
    |=> o_port_oe[8])
    else $error("phase 1 low window missing");
  blink_polarity_a: assert property (
    (master_ff != LIP_MASTER_OFF && ninth_ff == LIP_LEVEL_STATIC)
    |=> (o_port_oe[8] == !$past(i_blink_phase ? i_phase1_bits[8] : i_phase0_bits[8])))
    else $error("static level ignores the bit of the current blink phase");
  drain_only_a: assert property (
    o_port_out == '0)
    else $error("open-drain output driven high");

  // register bus checks
  rw_order_a: assert property (
    (i_reg_req.rd && i_reg_req.wr && i_reg_req.addr == LIP_ADDR_MASTER)
    |=> (o_reg_rdata == $past({master_ff, ninth_ff})))
    else $error("read in a write cycle does not return the old value");
  rdata_hold_a: assert property (
    !i_reg_req.rd |=> $stable(o_reg_rdata))
    else $error("read data changes without a read");
  level_hold_a: assert property (
    !i_reg_req.wr |=> $stable(master_ff) && $stable(ninth_ff))
    else $error("master or ninth level changes without a write");
  pair_read_a: assert property (
    (i_reg_req.rd && !i_reg_req.wr && i_reg_req.addr == LIP_ADDR_PAIR_LO + 8'h02)
    |=> (o_reg_rdata == {level_ff[5], level_ff[4]}))
    else $error("output pair read-back in wrong nibbles");

  // oscillator checks
  sub_range_a: assert property (
    sub_ff <= LIP_SUB_LAST)
    else $error("sub-step counter leaves the 15-step slot");
  sub_wrap_a: assert property (
    (osc_state_ff == LIP_OSC_RUN && master_ff != LIP_MASTER_OFF && div_ff == LIP_DIV_LAST
     && sub_ff == LIP_SUB_LAST) |=> (sub_ff == LIP_CNT_RST))
    else $error("sub-step counter does not wrap after step 15");
  div_hold_a: assert property (
    (master_ff != LIP_MASTER_OFF && div_ff != LIP_DIV_LAST)
    |=> $stable(sub_ff) && $stable(slot_ff))
    else $error("pwm position moves between divider ends");
  osc_start_a: assert property (
    (master_ff != LIP_MASTER_OFF && osc_state_ff == LIP_OSC_OFF)
    |=> (sub_ff == LIP_CNT_RST) && (slot_ff == LIP_CNT_RST) && (div_ff == LIP_DIV_RST))
    else $error("oscillator does not restart from the cycle start");

endmodule
`default_nettype wire

/* File: verification/lip_host_model.sv */
// host model: register writes and reads toward the block
`default_nettype none
module lip_host_model
  import lip_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // register access
  output var lip_reg_req_s o_req,
  input  wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: strobes low, address parked on an unmapped value
  initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'h00};
  // one write strobe, released with address and data inverted
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    #1 o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // write and read strobes in one cycle, old contents taken after the edge
  task automatic rw_reg(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    #1 o_req = '{wr: 1'b1, rd: 1'b1, addr: a, wdata: d};
    @(posedge i_clk);
    #1 q = i_rdata;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one read strobe, data taken after the edge that accepts it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1 o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    #1 d = i_rdata;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// testbench: register access and pwm duty of the led intensity block
`default_nettype none
module testbench;
  import lip_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         i_clk = 1'b0;
  logic         i_resetn = 1'b0;
  logic         blink = 1'b0;
  logic [8:0]   ph0 = '0;
  logic [8:0]   ph1 = '0;
  lip_reg_req_s req;
  logic [7:0]   rdata;
  logic [8:0]   pout;
  logic [8:0]   oe;
  logic [8:0]   plvl;
  wire logic [8:0] pin = ~oe; // pull-up wherever nothing sinks
  int           n_errors = 0;
  int           comparisons = 0;
  // clock
  always #5 i_clk = ~i_clk;
  lip_pwm_top i_lip_pwm_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_req(req),
    .o_reg_rdata(rdata), .i_blink_phase(blink), .i_phase0_bits(ph0),
    .i_phase1_bits(ph1), .i_port_in(pin), .o_port_out(pout), .o_port_oe(oe),
    .o_port_level(plvl));
  lip_host_model i_host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));
  // compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // read one register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd_reg(a, d);
    check("register read", {8'h00, exp}, {8'h00, d});
  endtask
  // count sink clocks of one output over a full pwm cycle
  task automatic duty(input int idx, input logic [15:0] exp);
    logic [15:0] cnt;
    logic        bad;
    cnt = '0;
    bad = 1'b0;
    repeat (3) @(posedge i_clk);
    repeat (960) begin
      @(posedge i_clk);
      #1 cnt += 16'(oe[idx]);
      bad |= pout[idx];
    end
    check("sink clocks", exp, cnt);
    check("pin value", 16'h0, {15'h0, bad});
  endtask
  // reset values, read-back, pairing, unmapped place
  task automatic t_regs();
    logic [7:0] d;
    rd_chk(LIP_ADDR_MASTER, 8'h00);
    check("oe after reset", 16'h0, {7'h0, oe});
    i_host.wr_reg(LIP_ADDR_MASTER, 8'h73);
    rd_chk(LIP_ADDR_MASTER, 8'h73);
    i_host.rw_reg(LIP_ADDR_MASTER, 8'h5c, d);
    check("read in write cycle", 16'h0073, {8'h00, d});
    rd_chk(LIP_ADDR_MASTER, 8'h5c);
    for (int a = 16; a < 20; a++) i_host.wr_reg(8'(a), 8'(a * 9));
    for (int a = 16; a < 20; a++) rd_chk(8'(a), 8'(a * 9));
    i_host.wr_reg(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
  endtask
  // every ninth-output level in both polarities, full master
  task automatic t_levels();
    for (int n = 0; n < 16; n++) begin
      i_host.wr_reg(LIP_ADDR_MASTER, {4'hf, 4'(n)});
      ph0[8] = 1'b0;
      duty(8, (n == 15) ? 16'd960 : 16'((n + 1) * 60));
      if (n == 15) check("pin level", 16'h0, {15'h0, plvl[8]});
      ph0[8] = 1'b1;
      duty(8, (n == 15) ? 16'd0 : 16'((15 - n) * 60));
    end
    ph0[8] = 1'b0;
    i_host.wr_reg(8'h10, 8'hf3);
    duty(0, 16'd240);
    duty(1, 16'd960);
  endtask
  // master scaling of a mid level
  task automatic t_master();
    for (int m = 1; m < 15; m += 6) begin
      i_host.wr_reg(LIP_ADDR_MASTER, {4'(m), 4'h7});
      duty(8, 16'(32 * m));
    end
  endtask
  // polarity follows the bit of the current blink phase
  task automatic t_blink();
    i_host.wr_reg(LIP_ADDR_MASTER, 8'hf3);
    ph1[8] = 1'b1;
    blink = 1'b0;
    duty(8, 16'd240);
    blink = 1'b1;
    duty(8, 16'd720);
    blink = 1'b0;
    ph1[8] = 1'b0;
  endtask
  // master zero turns outputs 8 and 1 off, both at static level
  task automatic t_off();
    i_host.wr_reg(LIP_ADDR_MASTER, 8'h0f);
    duty(8, 16'd0);
    duty(1, 16'd0);
  endtask
  // mid-run reset clears levels, read data and pins
  task automatic t_reset();
    i_host.wr_reg(LIP_ADDR_MASTER, 8'hff);
    ph0[8] = 1'b1;
    ph1[8] = 1'b0;
    blink = 1'b1;
    rd_chk(LIP_ADDR_MASTER, 8'hff);
    repeat (2) @(posedge i_clk);
    #1 check("oe static low", 16'h1, {15'h0, oe[8]});
    i_resetn = 1'b0;
    #1 check("oe in reset", 16'h0, {7'h0, oe});
    check("rdata in reset", 16'h0, {8'h0, rdata});
    check("pin level in reset", 16'h0, {7'h0, plvl});
    repeat (16) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    rd_chk(LIP_ADDR_MASTER, 8'h00);
    repeat (3) @(posedge i_clk);
    #1 check("oe after reset", 16'h0, {7'h0, oe});
    check("pin level after reset", 16'h1ff, {7'h0, plvl});
  endtask
  // verdict
  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    t_regs();
    t_levels();
    t_master();
    t_blink();
    t_off();
    t_reset();
    results();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
